/* rtl/sbs_tap.v */
/*
 * boundary-scan test access port: tap state machine, instruction,
 * bypass, boundary and identification registers, serial output.
 * assumes tck, tms and tdi arrive from pins asynchronous to clock,
 * with pull-ups modelled by the *Driven inputs; pin ring is sampled.
 */
`timescale 1ns/1ps
`include "sbs_tap_regs.vh"

// Overview of operation
// - sample on tck rise, launch on fall
// - undriven tms acts as logic one
// - undriven tdi shifts in logic one
// - tdo driven only in shift states
// - five tms-high edges reach reset state
// - reset state entered at power-up
// - no tck toggling leaves port inactive
// - one register between tdi and tdo
// - three-bit instruction, loaded only when selected
// - instruction acts after update, idle or dr
// - reset presets identification-read instruction
// - bypass is a single flip-flop
// - boundary captures pins, spare cells one
// - boundary captures then shifts in dr
// - boundary selected by extest, sample, sample-z
// - identification captures 32-bit constant
// - identification shifts out bit 0 first
// - capture instruction loads 01 into low bits
// - instruction codes per standard encoding table
// - sample-z forces memory outputs high impedance
module sbs_tap (
	// clock and reset
	input wire clock,
	input wire rst,
	// test pins
	input wire tck,
	input wire tms,
	input wire tmsDriven,
	input wire tdi,
	input wire tdiDriven,
	output reg tdo,
	output reg tdoOe_n,
	// pin ring and memory output control
	input wire [`SBS_PIN_W-1:0] pinRing,
	output reg memOutHiZ,
	output reg [`SBS_BSR_W-1:0] bsrParallel,
	output reg extestDrive,
	// observed state
	output wire [3:0] tapState
);
	reg [2:0] tckSync_q;
	reg tmsA_q, tmsB_q, tdiA_q, tdiB_q;
	reg [3:0] state_q, state_d;
	reg [`SBS_IR_W-1:0] irShift_q, ir_q;
	reg bypass_q;
	reg [`SBS_BSR_W-1:0] bsr_q;
	reg [`SBS_ID_W-1:0] id_q;
	reg serialBit;
	wire tckRise, tckFall, tmsIn, tdiIn, shDr, shIr, bsrSel, idSel, bypSel;
	wire [`SBS_BSR_W-1:0] bsrCapture;
	reg [`SBS_PIN_W-1:0] pinA_q, pinB_q;

	// tap state codes
	localparam [3:0] ST_RESET = `SBS_ST_RESET;
	localparam [3:0] ST_IDLE = `SBS_ST_IDLE;
	localparam [3:0] ST_SELDR = `SBS_ST_SELDR;
	localparam [3:0] ST_CAPDR = `SBS_ST_CAPDR;
	localparam [3:0] ST_SHDR = `SBS_ST_SHDR;
	localparam [3:0] ST_EX1DR = `SBS_ST_EX1DR;
	localparam [3:0] ST_PAUDR = `SBS_ST_PAUDR;
	localparam [3:0] ST_EX2DR = `SBS_ST_EX2DR;
	localparam [3:0] ST_UPDR = `SBS_ST_UPDR;
	localparam [3:0] ST_SELIR = `SBS_ST_SELIR;
	localparam [3:0] ST_CAPIR = `SBS_ST_CAPIR;
	localparam [3:0] ST_SHIR = `SBS_ST_SHIR;
	localparam [3:0] ST_EX1IR = `SBS_ST_EX1IR;
	localparam [3:0] ST_PAUIR = `SBS_ST_PAUIR;
	localparam [3:0] ST_EX2IR = `SBS_ST_EX2IR;
	localparam [3:0] ST_UPIR = `SBS_ST_UPIR;

	// pin synchronisers; first stage read only by second
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tckSync_q <= 3'h0;
			tmsA_q <= 1'b1;
			tmsB_q <= 1'b1;
			tdiA_q <= 1'b1;
			tdiB_q <= 1'b1;
			pinA_q <= {`SBS_PIN_W{1'b0}};
			pinB_q <= {`SBS_PIN_W{1'b0}};
		end else begin
			tckSync_q <= {tckSync_q[1:0], tck};
			tmsA_q <= tms | ~tmsDriven;
			tmsB_q <= tmsA_q;
			tdiA_q <= tdi | ~tdiDriven;
			tdiB_q <= tdiA_q;
			pinA_q <= pinRing;
			pinB_q <= pinA_q;
		end
	end

	assign tckRise = tckSync_q[1] & ~tckSync_q[2];
	assign tckFall = ~tckSync_q[1] & tckSync_q[2];
	assign tmsIn = tmsB_q;
	assign tdiIn = tdiB_q;
	assign tapState = state_q;
	assign shDr = (state_q == `SBS_ST_SHDR);
	assign shIr = (state_q == `SBS_ST_SHIR);
	assign bsrSel = (ir_q == `SBS_INS_EXTEST) || (ir_q == `SBS_INS_SAMPLE) || (ir_q == `SBS_INS_SAMPZ);
	assign idSel = (ir_q == `SBS_INS_IDREAD);
	assign bypSel = ~bsrSel & ~idSel;

	// pin cells low, spare cells tied to one
	assign bsrCapture = {{(`SBS_BSR_W-`SBS_PIN_W){1'b1}}, pinB_q};

	// next state from tms sampled on tck rise
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_RESET: begin
				if (tmsIn) begin
					state_d = ST_RESET;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (tmsIn) begin
					state_d = ST_SELDR;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_SELDR: begin
				if (tmsIn) begin
					state_d = ST_SELIR;
				end else begin
					state_d = ST_CAPDR;
				end
			end
			ST_CAPDR: begin
				if (tmsIn) begin
					state_d = ST_EX1DR;
				end else begin
					state_d = ST_SHDR;
				end
			end
			ST_SHDR: begin
				if (tmsIn) begin
					state_d = ST_EX1DR;
				end else begin
					state_d = ST_SHDR;
				end
			end
			ST_EX1DR: begin
				if (tmsIn) begin
					state_d = ST_UPDR;
				end else begin
					state_d = ST_PAUDR;
				end
			end
			ST_PAUDR: begin
				if (tmsIn) begin
					state_d = ST_EX2DR;
				end else begin
					state_d = ST_PAUDR;
				end
			end
			ST_EX2DR: begin
				if (tmsIn) begin
					state_d = ST_UPDR;
				end else begin
					state_d = ST_SHDR;
				end
			end
			ST_UPDR: begin
				if (tmsIn) begin
					state_d = ST_SELDR;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_SELIR: begin
				if (tmsIn) begin
					state_d = ST_RESET;
				end else begin
					state_d = ST_CAPIR;
				end
			end
			ST_CAPIR: begin
				if (tmsIn) begin
					state_d = ST_EX1IR;
				end else begin
					state_d = ST_SHIR;
				end
			end
			ST_SHIR: begin
				if (tmsIn) begin
					state_d = ST_EX1IR;
				end else begin
					state_d = ST_SHIR;
				end
			end
			ST_EX1IR: begin
				if (tmsIn) begin
					state_d = ST_UPIR;
				end else begin
					state_d = ST_PAUIR;
				end
			end
			ST_PAUIR: begin
				if (tmsIn) begin
					state_d = ST_EX2IR;
				end else begin
					state_d = ST_PAUIR;
				end
			end
			ST_EX2IR: begin
				if (tmsIn) begin
					state_d = ST_UPIR;
				end else begin
					state_d = ST_SHIR;
				end
			end
			ST_UPIR: begin
				if (tmsIn) begin
					state_d = ST_SELDR;
				end else begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_RESET;
		endcase
	end

	// rising-edge work: state, capture and shift
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= `SBS_ST_RESET;
			irShift_q <= `SBS_INS_IDREAD;
			ir_q <= `SBS_INS_IDREAD;
			bypass_q <= 1'b0;
			bsr_q <= {`SBS_BSR_W{1'b1}};
			id_q <= `SBS_ID_VALUE;
		end else if (tckRise) begin
			state_q <= state_d;
			if (state_q == `SBS_ST_RESET) begin
				ir_q <= `SBS_INS_IDREAD;
			end else if (state_q == `SBS_ST_UPIR) begin
				ir_q <= irShift_q;
			end
			if (state_q == `SBS_ST_CAPIR) begin
				irShift_q <= {irShift_q[`SBS_IR_W-1:2], 2'b01};
			end else if (shIr) begin
				irShift_q <= {tdiIn, irShift_q[`SBS_IR_W-1:1]};
			end
			if (state_q == `SBS_ST_CAPDR) begin
				bypass_q <= 1'b0;
				if (bsrSel) begin
					bsr_q <= bsrCapture;
				end
				if (idSel) begin
					id_q <= `SBS_ID_VALUE;
				end
			end else if (shDr) begin
				if (bypSel) begin
					bypass_q <= tdiIn;
				end
				if (bsrSel) begin
					bsr_q <= {tdiIn, bsr_q[`SBS_BSR_W-1:1]};
				end
				if (idSel) begin
					id_q <= {tdiIn, id_q[`SBS_ID_W-1:1]};
				end
			end
		end
	end

	// selected register's serial bit
	always @* begin
		if (shIr) begin
			serialBit = irShift_q[0];
		end else if (bsrSel) begin
			serialBit = bsr_q[0];
		end else if (idSel) begin
			serialBit = id_q[0];
		end else begin
			serialBit = bypass_q;
		end
	end

	// falling-edge launch of serial output and memory controls
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			tdo <= 1'b1;
			tdoOe_n <= 1'b1;
			memOutHiZ <= 1'b0;
			extestDrive <= 1'b0;
			bsrParallel <= {`SBS_BSR_W{1'b1}};
		end else if (tckFall) begin
			tdo <= serialBit;
			tdoOe_n <= ~(shDr | shIr);
			memOutHiZ <= (ir_q == `SBS_INS_SAMPZ);
			extestDrive <= (ir_q == `SBS_INS_EXTEST);
			if (state_q == `SBS_ST_UPDR) begin
				bsrParallel <= bsr_q;
			end
		end
	end
endmodule

/* rtl/sbs_tap_regs.vh */
/*
 * constants of the boundary-scan test access port: state codes,
 * instruction codes, register widths and reset values.
 * assumes inclusion by bare name from the rtl folder.
 */
`ifndef SBS_TAP_REGS_VH
`define SBS_TAP_REGS_VH

`define SBS_IR_W 3
`define SBS_ID_W 32
`define SBS_BSR_W 16
`define SBS_PIN_W 12

`define SBS_INS_EXTEST 3'h0
`define SBS_INS_IDREAD 3'h1
`define SBS_INS_SAMPZ 3'h2
`define SBS_INS_SAMPLE 3'h4
`define SBS_INS_BYPASS 3'h7

`define SBS_IR_CAPTURE 3'h1
`define SBS_ID_VALUE 32'h5A5A_A001
`define SBS_TMS_RESET_EDGES 3'h5

`define SBS_ST_RESET 4'hF
`define SBS_ST_IDLE 4'hC
`define SBS_ST_SELDR 4'h7
`define SBS_ST_CAPDR 4'h6
`define SBS_ST_SHDR 4'h2
`define SBS_ST_EX1DR 4'h1
`define SBS_ST_PAUDR 4'h3
`define SBS_ST_EX2DR 4'h0
`define SBS_ST_UPDR 4'h5
`define SBS_ST_SELIR 4'h4
`define SBS_ST_CAPIR 4'hE
`define SBS_ST_SHIR 4'hA
`define SBS_ST_EX1IR 4'h9
`define SBS_ST_PAUIR 4'hB
`define SBS_ST_EX2IR 4'h8
`define SBS_ST_UPIR 4'hD

`endif

/* verif/sbs_ctl_model.sv */
/* scan controller model: one tck period per step.
 assumes a free running clock for pacing. */
`timescale 1ns/1ps
module sbs_ctl_model (
	input wire clock,
	input wire tdo,
	input wire tdoOe_n,
	output reg tck, tms, tmsDriven, tdi, tdiDriven
);
	reg tmsFloat = 1'b0;
	reg tdiFloat = 1'b0;
	initial {tck, tms, tmsDriven, tdi, tdiDriven} = 5'h0F;
	task step(input reg m, input reg d, output reg so);
		begin
			// floating pins show a toggling level
			{tmsDriven, tdiDriven} = {!tmsFloat, !tdiFloat};
			tms = tmsFloat ? !tms : m;
			tdi = tdiFloat ? !tdi : d;
			repeat (12) @(negedge clock);
			// released output shows the inverse of its last level
			so = tdoOe_n ? !tdo : tdo;
			tck = 1'b1;
			repeat (12) @(negedge clock);
			tck = 1'b0;
			@(negedge clock);
		end
	endtask
endmodule

/* verif/sbs_tap_sva.sv */
/* port assertions of the test access port.
 assumes bind onto sbs_tap, clock domain only. */
`timescale 1ns/1ps
`include "sbs_tap_regs.vh"
module sbs_tap_sva (
	// watched ports
	input wire clock, rst, tck, tdo, tdoOe_n, memOutHiZ, extestDrive,
	input wire [3:0] tapState
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	property p_oe; $fell(tdoOe_n) |-> tapState inside {`SBS_ST_SHDR, `SBS_ST_SHIR}; endproperty
	a_oe: assert property (p_oe) else $error("tdo enabled outside shift");
	property p_fall; $changed(tdo) |-> !tck; endproperty
	a_fall: assert property (p_fall) else $error("tdo moved with tck high");
	property p_rise; $changed(tapState) |-> tck; endproperty
	a_rise: assert property (p_rise) else $error("state moved with tck low");
	property p_idle; $stable(tck) [*8] |-> $stable(tapState); endproperty
	a_idle: assert property (p_idle) else $error("state moved without tck");
	property p_hiz; $rose(memOutHiZ) |-> tapState inside {`SBS_ST_IDLE, `SBS_ST_SELDR}; endproperty
	a_hiz: assert property (p_hiz) else $error("hiz outside update");
	property p_ext; $rose(extestDrive) |-> tapState inside {`SBS_ST_IDLE, `SBS_ST_SELDR}; endproperty
	a_ext: assert property (p_ext) else $error("extest outside update");
	property p_shx; $past(tapState) == `SBS_ST_SHDR |-> tapState inside {`SBS_ST_SHDR, `SBS_ST_EX1DR}; endproperty
	a_shx: assert property (p_shx) else $error("bad shift exit");
	property p_rsx; $past(tapState) == `SBS_ST_RESET |-> tapState inside {`SBS_ST_RESET, `SBS_ST_IDLE}; endproperty
	a_rsx: assert property (p_rsx) else $error("bad reset exit");
	c_sh: cover property (tapState == `SBS_ST_SHIR);
	c_hz: cover property (memOutHiZ);
	c_ex: cover property (extestDrive);
endmodule

/* verif/tb.sv */
/* self-checking bench of the test access port.
 assumes the scan controller model drives the pins. */
`timescale 1ns/1ps
`include "sbs_tap_regs.vh"
module tb;
	reg clock = 1'b0;
	reg rst = 1'b1;
	reg [11:0] pinRing = 12'h000;
	reg [31:0] lfsr = 32'h02DA;
	reg [31:0] got;
	reg so;
	integer errors = 0;
	integer checks_done = 0;
	integer i, c;
	wire tck, tms, tmsDriven, tdi, tdiDriven, tdo, tdoOe_n, memOutHiZ, extestDrive;
	wire [15:0] bsrParallel;
	wire [3:0] tapState;
	sbs_tap sbs_tap_inst (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tmsDriven(tmsDriven), .tdi(tdi),
		.tdiDriven(tdiDriven), .tdo(tdo), .tdoOe_n(tdoOe_n), .pinRing(pinRing), .memOutHiZ(memOutHiZ),
		.bsrParallel(bsrParallel), .extestDrive(extestDrive), .tapState(tapState));
	sbs_ctl_model sbs_ctl_model_inst (.clock(clock), .tdo(tdo), .tdoOe_n(tdoOe_n), .tck(tck), .tms(tms),
		.tmsDriven(tmsDriven),
		.tdi(tdi), .tdiDriven(tdiDriven));
	initial forever #2.5 clock = !clock;
	task st(input reg m);
		sbs_ctl_model_inst.step(m, 1'b0, so);
	endtask
	task cmp(input string nm, input reg [31:0] e, input reg [31:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("[ERR] %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// from idle through a dr or ir scan back to idle
	task shift(input integer n, input reg [31:0] d, input reg ir);
		begin
			got = 32'h0;
			st(1'b1);
			if (ir)
				st(1'b1);
			st(1'b0);
			st(1'b0);
			for (i = 0; i < n; i = i + 1) begin
				sbs_ctl_model_inst.step(i == n - 1, d[i], so);
				got = {so, got[31:1]};
			end
			st(1'b1);
			st(1'b0);
			got = got >> (32 - n);
		end
	endtask
	function [31:0] lfsr_next(input [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [31:0] expect_dr(input [2:0] code, input [15:0] d, input [11:0] p);
		case (code)
			`SBS_INS_IDREAD: expect_dr = `SBS_ID_VALUE & 32'h0000FFFF;
			`SBS_INS_EXTEST, `SBS_INS_SAMPZ, `SBS_INS_SAMPLE: expect_dr = {16'h0000, 4'hF, p};
			default: expect_dr = {16'h0000, d[14:0], 1'b0};
		endcase
	endfunction
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", checks_done, errors);
			if (errors == 0 && checks_done > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		repeat (12) @(negedge clock);
		rst = 1'b0;
		repeat (3) @(negedge clock);
		cmp("state", `SBS_ST_RESET, tapState);
		st(1'b0);
		shift(32, 32'h0, 1'b0);
		cmp("idcode", `SBS_ID_VALUE, got);
		$display("test reset_id done");
		for (c = 0; c < 8; c = c + 1) begin
			shift(3, c, 1'b1);
			cmp("ircap", 32'h1, got & 32'h3);
			lfsr = lfsr_next(lfsr);
			pinRing = lfsr[11:0];
			shift(16, lfsr[31:16], 1'b0);
			cmp("dr", expect_dr(c, lfsr[31:16], pinRing), got);
			cmp("hiz", c == 2, memOutHiZ);
			cmp("extest", c == 0, extestDrive);
			cmp("oe", 32'h1, tdoOe_n);
			if (c == 0 || c == 2 || c == 4)
				cmp("parallel", lfsr[31:16], bsrParallel);
		end
		$display("test instructions done");
		sbs_ctl_model_inst.tdiFloat = 1'b1;
		shift(16, 32'h0, 1'b0);
		cmp("tdifloat", 32'hFFFE, got);
		sbs_ctl_model_inst.tdiFloat = 1'b0;
		st(1'b1);
		st(1'b0);
		st(1'b0);
		sbs_ctl_model_inst.tmsFloat = 1'b1;
		repeat (5) st(1'b0);
		sbs_ctl_model_inst.tmsFloat = 1'b0;
		cmp("reset5", `SBS_ST_RESET, tapState);
		st(1'b0);
		shift(32, 32'h0, 1'b0);
		cmp("idpreset", `SBS_ID_VALUE, got);
		$display("test tms_reset done");
		tally_and_finish;
	end
endmodule
bind sbs_tap sbs_tap_sva sbs_tap_sva_inst (.clock(clock), .rst(rst), .tck(tck), .tdo(tdo), .tdoOe_n(tdoOe_n),
	.memOutHiZ(memOutHiZ), .extestDrive(extestDrive), .tapState(tapState));
